// ===== shared/msp_consts.svh
// Offsets, field positions, reset values and size codes of the memory size and partition block.
// Function
// - Data RAM size register is a read-only byte count, 4 KB up to 64 KB.
// - Program flash size register is a read-only byte count, 16 KB up to 256 KB.
// - User flash base is writable in bits 19..11; bits 31..20 read zero.
// - Bits 10..0 of user flash base read zero, giving 2 KB steps.
// - Reset forces user flash base to zero, all flash kernel-owned.
`ifndef MSP_CONSTS_SVH
`define MSP_CONSTS_SVH

// ============================================================
// Register map.
`define MSP_ADDR_W 4
`define MSP_OFF_DATA_RAM_SIZE 4'h0
`define MSP_OFF_USER_FLASH_BASE 4'h4
`define MSP_OFF_PROGRAM_FLASH_SIZE 4'h8

// ============================================================
// Fields and reset values.
`define MSP_BASE_HI 19
`define MSP_BASE_LO 11
`define MSP_BASE_RESET 9'h000
`define MSP_RAM_4K 32'h0000_1000
`define MSP_RAM_8K 32'h0000_2000
`define MSP_RAM_16K 32'h0000_4000
`define MSP_RAM_32K 32'h0000_8000
`define MSP_RAM_64K 32'h0001_0000
`define MSP_FLASH_16K 32'h0000_4000
`define MSP_FLASH_32K 32'h0000_8000
`define MSP_FLASH_64K 32'h0001_0000
`define MSP_FLASH_128K 32'h0002_0000
`define MSP_FLASH_256K 32'h0004_0000

// ============================================================
// Bus answers.
`define MSP_RESP_OKAY 2'h0
`define MSP_RESP_SLVERR 2'h2

`endif

// ===== shared/msp_pkg.sv
// Types of the memory size and partition block.
package msp_pkg;
    typedef logic [31:0] msp_word_t;

    typedef struct packed {
        logic [1:0] resp;
        logic [31:0] data;
    } msp_rd_s;
endpackage : msp_pkg

// ===== hdl/msp_regs.sv
// AXI4-Lite register bank reporting memory sizes and the user flash base.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`include "msp_consts.svh"

module msp_regs
    import msp_pkg::*;
#(
    parameter logic [31:0] RAM_SIZE = `MSP_RAM_32K,
    parameter logic [31:0] FLASH_SIZE = `MSP_FLASH_128K
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Write address channel.
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [`MSP_ADDR_W-1:0] s_axi_awaddr_in,
    // Write data channel.
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    // Write response channel.
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // Read address channel.
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [`MSP_ADDR_W-1:0] s_axi_araddr_in,
    // Read data channel.
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    // Current partition boundary for the flash protection logic.
    output logic [31:0] user_flash_base_out
);

    // ============================================================
    // Address decode.
    function automatic logic is_mapped(input logic [`MSP_ADDR_W-1:0] a);
        logic r;
        r = 1'b0;
        if (a == `MSP_OFF_DATA_RAM_SIZE) begin
            r = 1'b1;
        end else if (a == `MSP_OFF_USER_FLASH_BASE) begin
            r = 1'b1;
        end else if (a == `MSP_OFF_PROGRAM_FLASH_SIZE) begin
            r = 1'b1;
        end
        return r;
    endfunction : is_mapped

    logic aw_held_q;
    logic w_held_q;
    logic [`MSP_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [8:0] base_q;
    logic [8:0] base_d;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    msp_rd_s rd_q;
    msp_rd_s rd_d;
    logic wr_go;
    logic ar_go;
    msp_word_t base_word;
    logic awready_q;
    logic wready_q;
    logic arready_q;

    assign base_word = {12'h000, base_q, 11'h000};
    assign wr_go = aw_held_q && w_held_q && !bvalid_q;
    assign ar_go = s_axi_arvalid_in && !rvalid_q;

    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out = wready_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = rd_q.data;
    assign s_axi_rresp_out = rd_q.resp;
    assign user_flash_base_out = base_word;

    // ============================================================
    // Write channel capture; address and data are taken in either order.
    // Ready flags are their own flip-flops so that no gate sits between a register and the bus.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
            awaddr_q <= '0;
        end else if (!aw_held_q && s_axi_awvalid_in) begin
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
            awaddr_q <= s_axi_awaddr_in;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (!w_held_q && s_axi_wvalid_in) begin
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q <= s_axi_wdata_in;
            wstrb_q <= s_axi_wstrb_in;
        end else if (wr_go) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    // ============================================================
    // User flash base; only bits 19..11 store, lanes 1 and 2 carry them.
    always_comb begin
        base_d = base_q;
        if (wr_go && awaddr_q == `MSP_OFF_USER_FLASH_BASE) begin
            if (wstrb_q[1]) begin
                base_d[4:0] = wdata_q[15:11];
            end
            if (wstrb_q[2]) begin
                base_d[8:5] = wdata_q[19:16];
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            base_q <= `MSP_BASE_RESET;
        end else begin
            base_q <= base_d;
        end
    end

    // ============================================================
    // Write response; writes to read-only registers answer OKAY and store nothing.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            bvalid_q <= 1'b0;
            bresp_q <= `MSP_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(awaddr_q) ? `MSP_RESP_OKAY : `MSP_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    // ============================================================
    // Read path.
    always_comb begin
        rd_d.resp = `MSP_RESP_OKAY;
        rd_d.data = 32'h0000_0000;
        if (s_axi_araddr_in == `MSP_OFF_DATA_RAM_SIZE) begin
            rd_d.data = RAM_SIZE;
        end else if (s_axi_araddr_in == `MSP_OFF_USER_FLASH_BASE) begin
            rd_d.data = base_word;
        end else if (s_axi_araddr_in == `MSP_OFF_PROGRAM_FLASH_SIZE) begin
            rd_d.data = FLASH_SIZE;
        end else begin
            rd_d.resp = `MSP_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
            rd_q <= '0;
        end else if (ar_go) begin
            rvalid_q <= 1'b1;
            arready_q <= 1'b0;
            rd_q <= rd_d;
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ============================================================
    // Assertions.
    sequence s_base_write;
        wr_go && awaddr_q == `MSP_OFF_USER_FLASH_BASE && wstrb_q[1] && wstrb_q[2];
    endsequence

    a_ram_size_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ar_go && s_axi_araddr_in == `MSP_OFF_DATA_RAM_SIZE |=> s_axi_rdata_out == RAM_SIZE)
        else $error("data RAM size read wrong");

    a_flash_size_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ar_go && s_axi_araddr_in == `MSP_OFF_PROGRAM_FLASH_SIZE
        |=> s_axi_rdata_out == FLASH_SIZE && s_axi_rresp_out == `MSP_RESP_OKAY)
        else $error("program flash size read wrong");

    a_base_store: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_base_write |=> user_flash_base_out[19:11] == $past(wdata_q[19:11]))
        else $error("user flash base did not store written bits");

    a_base_low_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        user_flash_base_out[10:0] == 11'h000 && user_flash_base_out[31:20] == 12'h000)
        else $error("user flash base read-only bits not zero");

    a_base_reset: assert property (@(posedge clk_sys_in)
        !rst_n_in |=> user_flash_base_out == 32'h0000_0000)
        else $error("user flash base not cleared by reset");

    a_ro_write_kept: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        wr_go && awaddr_q != `MSP_OFF_USER_FLASH_BASE |=> $stable(user_flash_base_out)
        ##0 bvalid_q)
        else $error("write to read-only register changed state");

    a_write_resp: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        wr_go && is_mapped(awaddr_q) |=> bvalid_q && bresp_q == `MSP_RESP_OKAY)
        else $error("mapped write not answered OKAY");

    a_base_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !wr_go |=> $stable(user_flash_base_out))
        else $error("user flash base changed without a write");

    // ============================================================
    // Strobe lanes, read masking and bus answers.
    // Each lane of the base field is checked alone, since a write may carry either lane.
    sequence s_lane1_write;
        wr_go && awaddr_q == `MSP_OFF_USER_FLASH_BASE && wstrb_q[1];
    endsequence

    sequence s_lane2_write;
        wr_go && awaddr_q == `MSP_OFF_USER_FLASH_BASE && wstrb_q[2];
    endsequence

    sequence s_lane1_skip;
        wr_go && awaddr_q == `MSP_OFF_USER_FLASH_BASE && !wstrb_q[1];
    endsequence

    sequence s_lane2_skip;
        wr_go && awaddr_q == `MSP_OFF_USER_FLASH_BASE && !wstrb_q[2];
    endsequence

    sequence s_ro_write;
        wr_go && (awaddr_q == `MSP_OFF_DATA_RAM_SIZE
            || awaddr_q == `MSP_OFF_PROGRAM_FLASH_SIZE);
    endsequence

    sequence s_base_read;
        ar_go && s_axi_araddr_in == `MSP_OFF_USER_FLASH_BASE;
    endsequence

    a_lane1_store: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_lane1_write |=> user_flash_base_out[15:11] == $past(wdata_q[15:11]))
        else $error("user flash base bits 15 to 11 not stored");

    a_lane2_store: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_lane2_write |=> user_flash_base_out[19:16] == $past(wdata_q[19:16]))
        else $error("user flash base bits 19 to 16 not stored");

    a_lane1_kept: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_lane1_skip |=> $stable(user_flash_base_out[15:11]))
        else $error("user flash base bits 15 to 11 changed without their strobe");

    a_lane2_kept: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_lane2_skip |=> $stable(user_flash_base_out[19:16]))
        else $error("user flash base bits 19 to 16 changed without their strobe");

    a_ro_write_okay: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_ro_write |=> s_axi_bresp_out == `MSP_RESP_OKAY && $stable(user_flash_base_out))
        else $error("write to a size register not ignored quietly");

    a_base_mask: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_base_read |=> s_axi_rdata_out == $past(user_flash_base_out)
            && s_axi_rdata_out[31:20] == 12'h000 && s_axi_rdata_out[10:0] == 11'h000)
        else $error("user flash base read wrong");

    a_ram_okay: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ar_go && s_axi_araddr_in == `MSP_OFF_DATA_RAM_SIZE
        |=> s_axi_rvalid_out && s_axi_rresp_out == `MSP_RESP_OKAY)
        else $error("data RAM size read not answered OKAY");

    a_reset_idle: assert property (@(posedge clk_sys_in)
        !rst_n_in |=> s_axi_awready_out && s_axi_wready_out && s_axi_arready_out
            && !s_axi_bvalid_out && !s_axi_rvalid_out)
        else $error("bus not idle after reset");

    a_ready_mirror: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_axi_awready_out == !aw_held_q && s_axi_wready_out == !w_held_q
            && s_axi_arready_out == !rvalid_q)
        else $error("ready flag disagrees with channel state");

    a_dead_lanes: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_lane1_skip and s_lane2_skip |=> $stable(user_flash_base_out))
        else $error("user flash base changed by a write without its lanes");

    a_wr_answer: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        wr_go |=> s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out)
        else $error("write not answered one cycle after it fired");

    a_rd_answer: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ar_go |=> s_axi_rvalid_out && !s_axi_arready_out)
        else $error("read not answered one cycle after it was taken");

endmodule : msp_regs

// ===== testbench/tb.sv
// Self-checking bench of the memory size and partition register bank.
`include "msp_consts.svh"

module tb
    import msp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] a_ram = `MSP_OFF_DATA_RAM_SIZE;
    localparam logic [3:0] a_base = `MSP_OFF_USER_FLASH_BASE;
    localparam logic [3:0] a_fl = `MSP_OFF_PROGRAM_FLASH_SIZE;
    localparam logic [1:0] ok = `MSP_RESP_OKAY;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    msp_word_t wdata = 32'h0000_0000, rdata, base_out, exp_base;
    logic [1:0] bresp, rresp;
    msp_rd_s exp_q[$];
    int err_total = 0, cmp_count = 0;

    always #2 clk_sys_in = ~clk_sys_in;

    msp_regs #(.RAM_SIZE(`MSP_RAM_32K), .FLASH_SIZE(`MSP_FLASH_128K)) dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .user_flash_base_out(base_out));

    // ============================================================
    // Comparison, verdict and timeout.
    task automatic check(input msp_rd_s seen, input msp_rd_s exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run

    task automatic hang_check(input int n);
        if (n == 50) begin
            err_total++;
            complete_run();
        end
    endtask : hang_check

    // ============================================================
    // Bus master tasks; each notes its expected answer first.
    task automatic wr(input logic [3:0] a, input msp_word_t d, input logic [3:0] s,
                      input logic [1:0] r);
        int n;
        msp_word_t m;
        m = 32'h000F_F800 & {8'h00, {8{s[2]}}, {8{s[1]}}, 8'h00};
        exp_q.push_back('{r, 32'h0000_0000});
        if (a == a_base && r == ok) exp_base = (exp_base & ~m) | (d & m);
        @(posedge clk_sys_in);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        hang_check(n);
    endtask : wr

    task automatic rd(input logic [3:0] a, input msp_word_t d, input logic [1:0] r);
        int n;
        exp_q.push_back('{r, d});
        @(posedge clk_sys_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys_in);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        hang_check(n);
    endtask : rd

    task automatic do_reset();
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        exp_base = 32'h0000_0000;
        @(posedge clk_sys_in);
        check('{2'h0, base_out}, '{2'h0, 32'h0000_0000});
    endtask : do_reset

    // ============================================================
    // Answer monitor: takes the oldest note at each handshake.
    always @(posedge clk_sys_in) begin
        if ((rvalid && rready) || (bvalid && bready)) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("Error at %0t: seen %h expected %h", $time, rdata, 0);
            end else if (rvalid && rready) begin
                check('{rresp, rdata}, exp_q.pop_front());
            end else begin
                check('{bresp, 32'h0000_0000}, exp_q.pop_front());
                check('{2'h0, base_out}, '{2'h0, exp_base});
            end
        end
    end

    // ============================================================
    // Main sequence.
    initial begin
        msp_word_t v;
        v = $urandom(1);
        do_reset();
        rd(a_ram, `MSP_RAM_32K, ok);
        rd(a_fl, `MSP_FLASH_128K, ok);
        rd(a_base, 32'h0000_0000, ok);
        wr(a_base, 32'hFFF1_FFFF, 4'hF, ok);
        rd(a_base, 32'h0001_F800, ok);
        wr(a_ram, 32'hFFFF_FFFF, 4'hF, ok);
        wr(a_fl, 32'h0000_0000, 4'hF, ok);
        rd(a_ram, `MSP_RAM_32K, ok);
        rd(a_fl, `MSP_FLASH_128K, ok);
        rd(a_base, 32'h0001_F800, ok);
        wr(4'hC, 32'h0000_F800, 4'hF, `MSP_RESP_SLVERR);
        rd(4'hC, 32'h0000_0000, `MSP_RESP_SLVERR);
        rd(a_base, 32'h0001_F800, ok);
        for (int i = 0; i < 24; i++) begin
            v = $urandom;
            wr(a_base, v & 32'hFFF1_FFFF, 4'($urandom), ok);
            rd(a_base, exp_base, ok);
        end
        wr(a_base, 32'h0001_0800, 4'hF, ok);
        do_reset();
        rd(a_base, 32'h0000_0000, ok);
        complete_run();
    end
endmodule : tb
